// ==== dv/avc_regs_test.sv ====
// Purpose: Self-checking bench for the control and status registers
// Assumes: Rotary base 0xEE00
// Notes:   Buffer readout is checked for one data word, then the invalid word after the trailer
`timescale 1ns/1ps
module avc_regs_test import avc_pkg::*;;
	logic        clock = 1'h0, rstn = 1'h0, as_n, ds_n, wr_n, iack_n, dtack_oe, berr_oe;
	logic        mrst, c_rdy = 1'h0, c_bsy = 1'h0, t_on = 1'h1, t_off = 1'h0;
	logic        no_slot = 1'h0, conv = 1'h0, mtest = 1'h1, empty = 1'h1, full = 1'h0;
	logic        front = 1'h0, event_trailer_word = 1'h0, stop_o, align_o, drst;
	logic [15:0] base = 16'hEE00;
	logic [31:1] addr;
	logic [31:0] wdata, rdata, v;
	logic [7:1]  irq_oe;
	logic [3:0]  chain;
	logic [5:0]  events = 6'h00;
	int          err_count = 0, compares = 0, cycles = 0;
	always #25 clock = ~clock;
	avc_regs i_avc_regs (.i_clock(clock), .i_rstn(rstn), .i_as_n(as_n), .i_ds_n(ds_n),
		.i_write_n(wr_n), .i_iack_n(iack_n), .i_addr(addr), .i_data(wdata), .o_data(rdata),
		.o_data_oe(), .o_dtack_n(), .o_dtack_oe(dtack_oe), .o_berr_n(), .o_berr_oe(berr_oe),
		.o_irq_n(), .o_irq_oe(irq_oe), .i_base_switch(16'hEE00), .i_chain_ready(c_rdy),
		.i_chain_busy(c_bsy), .i_term_on_all(t_on), .i_term_off_all(t_off),
		.i_slot_missing(no_slot), .i_front_reset(front), .i_daughter_type(4'hA),
		.i_conv_active(conv), .i_mem_test(mtest), .i_events_stored(events),
		.i_buf_empty(empty), .i_buf_full(full), .i_buf_word(32'h1234_5678),
		.i_buf_trailer(event_trailer_word), .o_buf_pop(), .o_module_reset(mrst), .o_data_reset(drst),
		.o_stop_after_first_event(stop_o), .o_align64(align_o),
		.o_chain_excluded(chain[3]), .o_chain_first(chain[2]),
		.o_chain_last(chain[1]), .o_chain_middle(chain[0]));
	avc_vme_master i_avc_vme_master (.i_clock(clock), .i_rd(rdata),
		.i_ack(dtack_oe | berr_oe), .o_as_n(as_n), .o_ds_n(ds_n), .o_write_n(wr_n),
		.o_iack_n(iack_n), .o_addr(addr), .o_data(wdata));
	task automatic check(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] ofs, wd);
		i_avc_vme_master.cycle(1'h1, 1'h0, {base, ofs}, wd, v);
	endtask
	task automatic rd(input logic [15:0] ofs, input logic [31:0] exp);
		i_avc_vme_master.cycle(1'h0, 1'h0, {base, ofs}, 16'h0, v);
		check($sformatf("reg %h", ofs), v, exp);
	endtask
	task automatic complete_run;
		$display("Compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clock) if (++cycles == 3000) begin
		err_count++;
		complete_run();
	end
	initial begin
		repeat (2) @(negedge clock);
		rstn = 1'h1;
		repeat (4) @(negedge clock);
		front = 1'h1;
		repeat (5) @(negedge clock);
		check("front data", 32'({mrst, drst}), 32'h1);
		front = 1'h0;
		rd(OFS_IRQ_ID, 32'h0);
		wr(OFS_IRQ_LEVEL, 16'hFFFB);
		rd(OFS_IRQ_LEVEL, 32'h3);
		wr(OFS_IRQ_ID, 16'hABCD);
		wr(OFS_THRESHOLD, 16'hFFE2);
		wr(OFS_RELOC_HI, 16'h0012);
		wr(OFS_RELOC_LO, 16'h0034);
		rd(OFS_RELOC_LO, 32'h34);
		wr(OFS_GROUP1_SET, 16'h0018);
		base = 16'h1234;
		rd(OFS_GROUP1_CLEAR, 32'h18);
		wr(OFS_GROUP1_CLEAR, 16'h0018);
		base = 16'hEE00;
		rd(OFS_GROUP1_SET, 32'h0);
		{c_rdy, c_bsy, t_on, t_off, no_slot, conv, mtest, empty, full} = 9'h1B9;
		events = 6'h02;
		rd(OFS_STATUS1, 32'h19F);
		check("irq", 32'(irq_oe), 32'h4);
		rd(OFS_STATUS2, 32'hA4);
		i_avc_vme_master.cycle(1'h0, 1'h1, 32'h6, 16'h0, v);
		check("vector", v, 32'hCD);
		wr(OFS_CONTROL, 16'hFFFF);
		rd(OFS_CONTROL, 32'h74);
		check("ctl outs", 32'({stop_o, align_o}), 32'h3);
		event_trailer_word = 1'h1;
		rd(16'h0000, 32'h1234_5678);
		rd(16'h0000, INVALID_WORD);
		rd(OFS_GROUP1_SET, 32'h8);
		wr(OFS_ONE_SHOT, 16'h0);
		check("reset", 32'(mrst), 32'h1);
		rd(OFS_CONTROL, 32'h10);
		rd(OFS_GROUP1_SET, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CHAIN, 16'(k));
			check("chain", 32'(chain), 32'(4'h8 >> {k[0], k[1]}));
		end
		front = 1'h1;
		repeat (5) @(negedge clock);
		check("front full", 32'({mrst, drst}), 32'h2);
		front = 1'h0;
		rd(OFS_CONTROL, 32'h10);
		complete_run();
	end
endmodule

// ==== dv/avc_vme_master.sv ====
// Purpose: VME master model making single read, write and interrupt acknowledge cycles
// Assumes: Lines change only on falling clock edges
// Notes:   Released data lines invert; a missing answer gives up after 12 cycles
`timescale 1ns/1ps
module avc_vme_master (
	// Clock and answer from the slave
	input  wire logic        i_clock,
	input  wire logic [31:0] i_rd,
	input  wire logic        i_ack,
	// Master lines
	output logic             o_as_n,
	output logic             o_ds_n,
	output logic             o_write_n,
	output logic             o_iack_n,
	output logic [31:1]      o_addr,
	output logic [31:0]      o_data
);
	initial {o_as_n, o_ds_n, o_write_n, o_iack_n, o_addr, o_data} = {4'hF, 63'h0};
	task automatic cycle(input logic wr, ia, input logic [31:0] a,
		input logic [15:0] wd, output logic [31:0] rd);
		int n;
		@(negedge i_clock);
		o_data = wr ? {16'h0000, wd} : ~o_data;
		o_addr = a[31:1];
		{o_write_n, o_iack_n, o_as_n, o_ds_n} = {!wr, !ia, 2'h0};
		for (n = 0; n < 12 && i_ack !== 1'h1; n++)
			@(negedge i_clock);
		rd = i_rd;
		{o_as_n, o_ds_n, o_iack_n} = 3'h7;
		o_data = ~o_data;
		for (n = 0; n < 12 && i_ack === 1'h1; n++)
			@(negedge i_clock);
	endtask
endmodule

// ==== rtl/avc_pkg.sv ====
// Purpose: Shared constants for the converter control and status registers
// Assumes: 16-bit registers at byte offsets from the module base address
// Notes:   Field positions not fixed by the register map are chosen here once
package avc_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [15:0] OFS_BUFFER_END   = 16'h1000;
	localparam logic [15:0] OFS_GROUP1_SET   = 16'h1006;
	localparam logic [15:0] OFS_GROUP1_CLEAR = 16'h1008;
	localparam logic [15:0] OFS_IRQ_LEVEL    = 16'h100A;
	localparam logic [15:0] OFS_IRQ_ID       = 16'h100C;
	localparam logic [15:0] OFS_STATUS1      = 16'h100E;
	localparam logic [15:0] OFS_CONTROL      = 16'h1010;
	localparam logic [15:0] OFS_RELOC_HI     = 16'h1012;
	localparam logic [15:0] OFS_RELOC_LO     = 16'h1014;
	localparam logic [15:0] OFS_ONE_SHOT     = 16'h1016;
	localparam logic [15:0] OFS_CHAIN        = 16'h101A;
	localparam logic [15:0] OFS_THRESHOLD    = 16'h1020;
	localparam logic [15:0] OFS_STATUS2      = 16'h1022;

	// ---------------------------------------------------------------
	// Field positions and masks
	// ---------------------------------------------------------------
	localparam int G1_BERR      = 3;
	localparam int G1_SELADDR   = 4;
	localparam int G1_SWRESET   = 7;
	localparam logic [7:0] G1_MASK = 8'h98;
	localparam int CTL_STOP     = 2;
	localparam int CTL_SCOPE    = 4;
	localparam int CTL_BERR_EN  = 5;
	localparam int CTL_ALIGN    = 6;
	localparam logic [6:0] CTL_MASK      = 7'h74;
	localparam logic [6:0] CTL_SOFT_KEEP = 7'h10;
	localparam int CHN_LAST     = 0;
	localparam int CHN_FIRST    = 1;
	localparam int S1_READY     = 0;
	localparam int S1_CHAIN_RDY = 1;
	localparam int S1_BUSY      = 2;
	localparam int S1_CHAIN_BSY = 3;
	localparam int S1_NO_SLOT   = 4;
	localparam int S1_PURGED    = 5;
	localparam int S1_TERM_ON   = 6;
	localparam int S1_TERM_OFF  = 7;
	localparam int S1_THR_HIT   = 8;
	localparam int S2_EMPTY     = 1;
	localparam int S2_FULL      = 2;
	localparam int S2_TYPE_LSB  = 4;
	localparam int LEVEL_W      = 3;
	localparam int THRESH_W     = 5;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]          GROUP1_RST  = 8'h00;
	localparam logic [6:0]          CONTROL_RST = 7'h00;
	localparam logic [LEVEL_W-1:0]  LEVEL_RST   = 3'h0;
	localparam logic [7:0]          ID_RST      = 8'h00;
	localparam logic [THRESH_W-1:0] THRESH_RST  = 5'h00;
	localparam logic [7:0]          RELOC_RST   = 8'h00;
	localparam logic [1:0]          CHAIN_RST   = 2'h0;
	localparam logic [31:0]         INVALID_WORD = 32'h0600_0000;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS   = 50;
	localparam int SHOT_RESET_NS     = 1000;
	localparam int SHOT_RESET_CYCLES =
		(SHOT_RESET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	typedef enum logic {ST_IDLE, ST_HOLD} avc_bus_state_t;

endpackage

// ==== rtl/avc_regs.sv ====
// Purpose: Control and status registers of the converter, VME slave side
// Assumes: A32 D16 single cycles for registers, D32 beats for buffer reads
// Notes:   Bus and board pins pass two flip-flops, datapath inputs do not; answers hold until strobe release
`timescale 1ns/1ps
module avc_regs
	import avc_pkg::*;
#(
	parameter int EVENT_CNT_W = 6
)(
	// Clock and reset
	input  wire logic                   i_clock,
	input  wire logic                   i_rstn,
	// VME slave pins
	input  wire logic                   i_as_n,
	input  wire logic                   i_ds_n,
	input  wire logic                   i_write_n,
	input  wire logic                   i_iack_n,
	input  wire logic [31:1]            i_addr,
	input  wire logic [31:0]            i_data,
	output logic      [31:0]            o_data,
	output logic                        o_data_oe,
	output logic                        o_dtack_n,
	output logic                        o_dtack_oe,
	output logic                        o_berr_n,
	output logic                        o_berr_oe,
	output logic      [7:1]             o_irq_n,
	output logic      [7:1]             o_irq_oe,
	// Board pins
	input  wire logic [15:0]            i_base_switch,
	input  wire logic                   i_chain_ready,
	input  wire logic                   i_chain_busy,
	input  wire logic                   i_term_on_all,
	input  wire logic                   i_term_off_all,
	input  wire logic                   i_slot_missing,
	input  wire logic                   i_front_reset,
	input  wire logic [3:0]             i_daughter_type,
	// Datapath
	input  wire logic                   i_conv_active,
	input  wire logic                   i_mem_test,
	input  wire logic [EVENT_CNT_W-1:0] i_events_stored,
	input  wire logic                   i_buf_empty,
	input  wire logic                   i_buf_full,
	input  wire logic [31:0]            i_buf_word,
	input  wire logic                   i_buf_trailer,
	output logic                        o_buf_pop,
	// Module control
	output logic                        o_module_reset,
	output logic                        o_data_reset,
	output logic                        o_stop_after_first_event,
	output logic                        o_align64,
	output logic                        o_chain_excluded,
	output logic                        o_chain_first,
	output logic                        o_chain_last,
	output logic                        o_chain_middle
);

	// ---------------------------------------------------------------
	// Parameter check
	// ---------------------------------------------------------------
	if (EVENT_CNT_W < THRESH_W) begin : g_bad_width
		$error("EVENT_CNT_W must be at least the threshold width");
	end

	localparam int SHOT_W = $clog2(SHOT_RESET_CYCLES + 1);

	function automatic logic is_mapped(input logic [15:0] ofs);
		case (ofs)
			OFS_GROUP1_SET, OFS_GROUP1_CLEAR, OFS_IRQ_LEVEL, OFS_IRQ_ID,
			OFS_STATUS1, OFS_CONTROL, OFS_RELOC_HI, OFS_RELOC_LO,
			OFS_ONE_SHOT, OFS_CHAIN, OFS_THRESHOLD, OFS_STATUS2: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Reset release and pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0]  rst_pipe;
	logic        rstn;
	logic        as_s, ds_s, write_s, iack_s;
	logic [31:1] addr_s;
	logic [31:0] data_s;
	logic        ready_s, busy_s, ton_s, toff_s, noslot_s, front_s;
	logic [3:0]  dtype_s;
	logic [15:0] base_sw_s;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rstn = rst_pipe[1];

	avc_sync2 #(.W(67), .RST_VAL({4'hF, 63'h0})) u_bus_sync (
		.i_clock (i_clock),
		.i_rstn  (rstn),
		.i_d     ({i_as_n, i_ds_n, i_write_n, i_iack_n, i_addr, i_data}),
		.o_q     ({as_s, ds_s, write_s, iack_s, addr_s, data_s})
	);

	avc_sync2 #(.W(26), .RST_VAL(26'h0)) u_pin_sync (
		.i_clock (i_clock),
		.i_rstn  (rstn),
		.i_d     ({i_chain_ready, i_chain_busy, i_term_on_all, i_term_off_all,
		           i_slot_missing, i_front_reset, i_daughter_type, i_base_switch}),
		.o_q     ({ready_s, busy_s, ton_s, toff_s, noslot_s, front_s, dtype_s,
		           base_sw_s})
	);

	// ---------------------------------------------------------------
	// Cycle decode
	// ---------------------------------------------------------------
	avc_bus_state_t state;
	logic [7:0]          group1, next_group1;
	logic [6:0]          ctl;
	logic [LEVEL_W-1:0]  irq_level;
	logic [7:0]          irq_id;
	logic [THRESH_W-1:0] threshold;
	logic [7:0]          reloc_hi, reloc_lo;
	logic [1:0]          chain;
	logic [SHOT_W-1:0]   shot_cnt;
	logic                irq_pending, thr_eq, thr_eq_q;
	logic                pad_pending, done, odd, purged;
	logic [15:0]         ofs, wdata, base, reg_rdata, status1, status2;
	logic                start, hit, reg_acc, reg_wr, buf_beat, iack_hit;
	logic                soft_rst, busy;
	logic                ans_go, ans_rd, berr_now, pop;
	logic [31:0]         ans_word;

	assign ofs   = {addr_s[15:1], 1'b0};
	assign wdata = data_s[15:0];
	assign base  = group1[G1_SELADDR] ? {reloc_hi, reloc_lo} : base_sw_s;
	assign start = (state == ST_IDLE) && !as_s && !ds_s;
	assign hit   = start && iack_s && (addr_s[31:16] == base);
	assign reg_acc  = hit && is_mapped(ofs);
	assign reg_wr   = reg_acc && !write_s;
	assign buf_beat = hit && write_s && (ofs < OFS_BUFFER_END);
	assign iack_hit = start && !iack_s && irq_pending && (addr_s[3:1] == irq_level);

	// ---------------------------------------------------------------
	// Mode group one, control and plain registers
	// ---------------------------------------------------------------
	always_comb begin
		next_group1 = group1;
		if (reg_wr && ofs == OFS_GROUP1_SET) begin
			next_group1 = group1 | (wdata[7:0] & G1_MASK);
		end
		if (reg_wr && ofs == OFS_GROUP1_CLEAR) begin
			next_group1 = group1 & ~wdata[7:0];
		end
		if (soft_rst) begin
			next_group1[G1_BERR] = 1'b0;
		end
		// A bus error in the same cycle as a clear still leaves its mark
		if (berr_now) begin
			next_group1[G1_BERR] = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			group1 <= GROUP1_RST;
		end else begin
			group1 <= next_group1;
		end
	end

	// Scope bit survives soft reset so a front reset cannot undo itself
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			ctl <= CONTROL_RST;
		end else if (soft_rst) begin
			ctl <= ctl & CTL_SOFT_KEEP;
		end else if (reg_wr && ofs == OFS_CONTROL) begin
			ctl <= wdata[6:0] & CTL_MASK;
		end
	end

	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			irq_level <= LEVEL_RST;
			irq_id    <= ID_RST;
			threshold <= THRESH_RST;
			reloc_hi  <= RELOC_RST;
			reloc_lo  <= RELOC_RST;
			chain     <= CHAIN_RST;
		end else if (reg_wr) begin
			case (ofs)
				OFS_IRQ_LEVEL: irq_level <= wdata[LEVEL_W-1:0];
				OFS_IRQ_ID:    irq_id    <= wdata[7:0];
				OFS_THRESHOLD: threshold <= wdata[THRESH_W-1:0];
				OFS_RELOC_HI:  reloc_hi  <= wdata[7:0];
				OFS_RELOC_LO:  reloc_lo  <= wdata[7:0];
				OFS_CHAIN:     chain     <= wdata[1:0];
				default:       chain     <= chain;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Resets
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			shot_cnt <= '0;
		end else if (reg_wr && ofs == OFS_ONE_SHOT) begin
			shot_cnt <= SHOT_W'(SHOT_RESET_CYCLES);
		end else if (shot_cnt != '0) begin
			shot_cnt <= shot_cnt - 1'b1;
		end
	end

	assign soft_rst = group1[G1_SWRESET] || (shot_cnt != '0)
		|| (front_s && ctl[CTL_SCOPE]);

	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			o_module_reset <= 1'b0;
			o_data_reset   <= 1'b0;
		end else begin
			o_module_reset <= soft_rst;
			o_data_reset   <= front_s && !ctl[CTL_SCOPE];
		end
	end

	a_one_shot_len: assert property (@(posedge i_clock) disable iff (!rstn)
		reg_wr && ofs == OFS_ONE_SHOT |=> ##1 o_module_reset [*8])
		else $error("one-shot write did not hold module reset");
	a_soft_keeps_scope: assert property (@(posedge i_clock) disable iff (!rstn)
		soft_rst |=> (ctl & ~CTL_SOFT_KEEP) == 7'h00 && ctl[CTL_SCOPE] == $past(ctl[CTL_SCOPE]))
		else $error("soft reset handled control bits wrongly");

	// ---------------------------------------------------------------
	// Interrupt request
	// ---------------------------------------------------------------
	assign thr_eq = (threshold != '0) && (irq_level != '0)
		&& (i_events_stored == EVENT_CNT_W'(threshold));

	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			thr_eq_q    <= 1'b0;
			irq_pending <= 1'b0;
		end else begin
			thr_eq_q <= thr_eq;
			if (thr_eq && !thr_eq_q) begin
				irq_pending <= 1'b1;
			end else if (iack_hit || soft_rst || irq_level == '0 || threshold == '0) begin
				irq_pending <= 1'b0;
			end
		end
	end

	always_comb begin
		o_irq_oe = 7'h00;
		if (irq_pending && irq_level != '0) begin
			o_irq_oe[irq_level] = 1'b1;
		end
	end
	assign o_irq_n = 7'h00;

	a_level_zero: assert property (@(posedge i_clock) disable iff (!rstn)
		irq_level == '0 |-> o_irq_oe == 7'h00)
		else $error("interrupt driven with level zero");
	a_thr_zero: assert property (@(posedge i_clock) disable iff (!rstn)
		threshold == '0 |=> !irq_pending)
		else $error("threshold zero still requests");

	// ---------------------------------------------------------------
	// Block readout sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			pad_pending <= 1'b0;
			done        <= 1'b0;
			odd         <= 1'b0;
			purged      <= 1'b0;
		end else if (soft_rst || o_data_reset) begin
			pad_pending <= 1'b0;
			done        <= 1'b0;
			odd         <= 1'b0;
			purged      <= 1'b0;
		end else begin
			// Releasing the address strobe closes the block
			if (as_s) begin
				done <= 1'b0;
			end
			if (buf_beat && pad_pending) begin
				pad_pending <= 1'b0;
			end
			if (pop) begin
				odd    <= i_buf_trailer ? 1'b0 : ~odd;
				purged <= 1'b0;
				if (i_buf_trailer) begin
					pad_pending <= ctl[CTL_ALIGN] && !odd;
					done        <= ctl[CTL_STOP];
					purged      <= ctl[CTL_STOP];
				end
			end
			if (buf_beat && !pad_pending && !pop) begin
				done   <= 1'b1;
				purged <= 1'b1;
			end
		end
	end

	always_comb begin
		ans_go   = 1'b0;
		ans_rd   = 1'b0;
		berr_now = 1'b0;
		pop      = 1'b0;
		ans_word = INVALID_WORD;
		if (iack_hit) begin
			ans_go   = 1'b1;
			ans_rd   = 1'b1;
			ans_word = {24'h000000, irq_id};
		end else if (buf_beat) begin
			ans_go = 1'b1;
			ans_rd = 1'b1;
			if (!pad_pending) begin
				if (done || i_buf_empty) begin
					berr_now = ctl[CTL_BERR_EN];
				end else begin
					ans_word = i_buf_word;
					pop      = 1'b1;
					berr_now = ctl[CTL_BERR_EN] && ctl[CTL_STOP] && i_buf_trailer;
				end
			end
		end else if (reg_acc) begin
			ans_go   = 1'b1;
			ans_rd   = write_s;
			ans_word = {16'h0000, reg_rdata};
		end
	end
	assign o_buf_pop = pop;

	a_pad_word: assert property (@(posedge i_clock) disable iff (!rstn)
		buf_beat && pad_pending |=> o_data == INVALID_WORD && !o_buf_pop)
		else $error("alignment pad word not returned");
	a_bus_error_raised: assert property (@(posedge i_clock) disable iff (!rstn)
		berr_now |=> o_berr_oe && !o_dtack_oe && group1[G1_BERR])
		else $error("bus error not signalled or not flagged");

	// ---------------------------------------------------------------
	// Answer phase
	// ---------------------------------------------------------------
	always_ff @(posedge i_clock or negedge rstn) begin
		if (!rstn) begin
			state      <= ST_IDLE;
			o_data     <= 32'h0000_0000;
			o_data_oe  <= 1'b0;
			o_dtack_oe <= 1'b0;
			o_berr_oe  <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (ans_go) begin
						state      <= ST_HOLD;
						o_data     <= ans_word;
						o_data_oe  <= ans_rd;
						o_dtack_oe <= !berr_now;
						o_berr_oe  <= berr_now;
					end
				end
				ST_HOLD: begin
					if (ds_s) begin
						state      <= ST_IDLE;
						o_data_oe  <= 1'b0;
						o_dtack_oe <= 1'b0;
						o_berr_oe  <= 1'b0;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	assign o_dtack_n = 1'b0;
	assign o_berr_n  = 1'b0;

	a_iack_vector: assert property (@(posedge i_clock) disable iff (!rstn)
		iack_hit |=> o_data == {24'h000000, $past(irq_id)} && o_dtack_oe && !irq_pending)
		else $error("acknowledge did not return the status id");

	// ---------------------------------------------------------------
	// Status and read mux
	// ---------------------------------------------------------------
	assign busy = i_conv_active || soft_rst || o_data_reset
		|| i_buf_full || i_mem_test;

	always_comb begin
		status1               = 16'h0000;
		status1[S1_READY]     = i_events_stored != '0;
		status1[S1_CHAIN_RDY] = ready_s;
		status1[S1_BUSY]      = busy;
		status1[S1_CHAIN_BSY] = busy_s;
		status1[S1_NO_SLOT]   = noslot_s;
		status1[S1_PURGED]    = purged;
		status1[S1_TERM_ON]   = ton_s;
		status1[S1_TERM_OFF]  = toff_s;
		status1[S1_THR_HIT]   = irq_pending;
		status2               = 16'h0000;
		status2[S2_EMPTY]     = i_buf_empty;
		status2[S2_FULL]      = i_buf_full;
		status2[S2_TYPE_LSB +: 4] = dtype_s;
	end

	always_comb begin
		case (ofs)
			OFS_GROUP1_SET, OFS_GROUP1_CLEAR: reg_rdata = {8'h00, group1};
			OFS_IRQ_LEVEL: reg_rdata = {13'h0000, irq_level};
			OFS_IRQ_ID:    reg_rdata = {8'h00, irq_id};
			OFS_STATUS1:   reg_rdata = status1;
			OFS_CONTROL:   reg_rdata = {9'h000, ctl};
			OFS_RELOC_HI:  reg_rdata = {8'h00, reloc_hi};
			OFS_RELOC_LO:  reg_rdata = {8'h00, reloc_lo};
			OFS_THRESHOLD: reg_rdata = {11'h000, threshold};
			OFS_STATUS2:   reg_rdata = status2;
			default:       reg_rdata = 16'h0000;
		endcase
	end

	a_ready_flag: assert property (@(posedge i_clock) disable iff (!rstn)
		reg_acc && write_s && ofs == OFS_STATUS1 |=> o_data[S1_READY] == ($past(i_events_stored) != '0))
		else $error("ready flag disagrees with stored events");
	a_busy_causes: assert property (@(posedge i_clock) disable iff (!rstn)
		(i_conv_active || i_buf_full || i_mem_test) |-> status1[S1_BUSY])
		else $error("busy flag missing");
	a_clear_bits: assert property (@(posedge i_clock) disable iff (!rstn)
		reg_wr && ofs == OFS_GROUP1_CLEAR && wdata[G1_SELADDR] |=> !group1[G1_SELADDR])
		else $error("clear write left bit set");

	// ---------------------------------------------------------------
	// Module control outputs
	// ---------------------------------------------------------------
	assign o_stop_after_first_event = ctl[CTL_STOP];
	assign o_align64        = ctl[CTL_ALIGN];
	assign o_chain_excluded = !chain[CHN_FIRST] && !chain[CHN_LAST];
	assign o_chain_first    = chain[CHN_FIRST] && !chain[CHN_LAST];
	assign o_chain_last     = !chain[CHN_FIRST] && chain[CHN_LAST];
	assign o_chain_middle   = chain[CHN_FIRST] && chain[CHN_LAST];

	a_chain_decode: assert property (@(posedge i_clock) disable iff (!rstn)
		reg_wr && ofs == OFS_CHAIN && wdata[1:0] == 2'h3 |=> o_chain_middle && !o_chain_first)
		else $error("chain position decoded wrongly");

endmodule

// ==== rtl/avc_sync2.sv ====
// Purpose: Two flip-flop synchroniser for a bundle of pin inputs
// Assumes: Bits of a bundle are stable together while they are sampled
// Notes:   Reset value is a parameter so idle-high strobes stay idle
`timescale 1ns/1ps
module avc_sync2 #(
	parameter int               W       = 1,
	parameter logic [W-1:0]     RST_VAL = '0
)(
	// Clock and reset
	input  wire logic         i_clock,
	input  wire logic         i_rstn,
	// Data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			meta <= RST_VAL;
			o_q  <= RST_VAL;
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule
